/* hdl/low_power_wake_fifo_select_cfg.sv */
// low-power, wake-on-motion, queue source select and frame-sync status registers
// Summary of operation
// - bit 7 of low_power_config enables gyroscope duty-cycling and resets to zero.
// - bits 6:4 of low_power_config pick 1x to 128x gyro averaging, reset 000.
// - while duty-cycling, gyro filtering follows the averaging field, not the low-pass choice.
// - bits 3:0 of low_power_config set the wake accelerometer rate, codes 4 to 11.
// - the wake rate applies only with the gyro off and accel duty-cycling on.
// - wake_motion_threshold holds an eight-bit motion threshold at 4 mg per step.
// - source bit 7 pushes temperature high then low byte on each sample tick.
// - source bits 6, 5, 4 push gyro X, Y, Z high and low bytes on each sample tick.
// - source bit 3 pushes all six accelerometer bytes, X to Z, high first.
// - enabled gyro or temperature sources are queued even when their path is in standby.
// - frame-sync status bit 7 sets on a frame-sync event and clears when read.
// - a frame-sync event is raised only when enabled, on a move to the chosen level.
// - wake-on-motion needs the gyro off and accel duty-cycling set by software.
// - the sample tick is the filter rate divided by one plus the rate divider.
`timescale 1ns/10ps
module low_power_wake_fifo_select_cfg (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        gyro_off,
  input  wire logic        accel_cycle_en,
  input  wire logic [2:0]  gyro_lowpass_sel,
  input  wire logic [7:0]  rate_divider,
  input  wire logic        filter_tick,
  input  wire logic        frame_sync_pin,
  input  wire logic        frame_sync_irq_en,
  input  wire logic        frame_sync_irq_polarity,
  input  wire logic [15:0] temp_value,
  input  wire logic [15:0] gyro_x_value,
  input  wire logic [15:0] gyro_y_value,
  input  wire logic [15:0] gyro_z_value,
  input  wire logic [15:0] accel_x_value,
  input  wire logic [15:0] accel_y_value,
  input  wire logic [15:0] accel_z_value,
  output logic             gyro_cycle_en,
  output logic      [2:0]  gyro_average_sel,
  output logic      [2:0]  gyro_lowpass_applied,
  output logic             wake_rate_active,
  output logic      [3:0]  wake_accel_rate_sel,
  output logic      [7:0]  motion_threshold,
  output logic             frame_sync_irq_flag,
  output logic             queue_push,
  output logic      [7:0]  queue_data
);
  typedef struct packed {
    logic [7:0]                     low_power_config;
    logic [7:0]                     wake_motion_threshold;
    logic [4:0]                     source_sel;
    logic                           irq_flag;
    logic [7:0]                     rdata;
    motion_cfg_pkg::seq_state_t     seq;
    logic [3:0]                     byte_index;
    logic [4:0]                     snap_sel;
    logic [16*motion_cfg_pkg::WORD_COUNT-1:0] snap_words;
    logic                           push;
    logic [7:0]                     data;
    logic [2:0]                     lowpass_applied;
    logic                           rate_active;
    logic [3:0]                     rate_sel;
  } cfg_state_t;

  cfg_state_t state;
  cfg_state_t next_state;
  logic       sample_tick;
  logic       frame_sync_event;

  sample_rate_divider rate_div (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .filter_tick  (filter_tick),
    .rate_divider (rate_divider),
    .sample_tick  (sample_tick)
  );

  frame_sync_detect sync_detect (
    .clk_sys                 (clk_sys),
    .reset                   (reset),
    .frame_sync_pin          (frame_sync_pin),
    .frame_sync_irq_en       (frame_sync_irq_en),
    .frame_sync_irq_polarity (frame_sync_irq_polarity),
    .frame_sync_event        (frame_sync_event)
  );

  // source 0 temp, 1..3 gyro x/y/z, 4..6 accel x/y/z; sel holds register bits 7..3
  function automatic logic source_enabled(input logic [4:0] sel, input logic [2:0] src);
    logic result;
    result = 1'b0;
    case (src)
      3'h0: result = sel[motion_cfg_pkg::SRC_TEMP_BIT - motion_cfg_pkg::SRC_FIELD_LSB];
      3'h1: result = sel[motion_cfg_pkg::SRC_GYRO_X_BIT - motion_cfg_pkg::SRC_FIELD_LSB];
      3'h2: result = sel[motion_cfg_pkg::SRC_GYRO_Y_BIT - motion_cfg_pkg::SRC_FIELD_LSB];
      3'h3: result = sel[motion_cfg_pkg::SRC_GYRO_Z_BIT - motion_cfg_pkg::SRC_FIELD_LSB];
      3'h4, 3'h5, 3'h6: result = sel[motion_cfg_pkg::SRC_ACCEL_BIT - motion_cfg_pkg::SRC_FIELD_LSB];
      default: result = 1'b0;
    endcase
    return result;
  endfunction

  // byte k of the snapshot; word 0 sits in the top bits, high byte before low byte
  function automatic logic [7:0] snapshot_byte(
    input logic [16*motion_cfg_pkg::WORD_COUNT-1:0] words,
    input logic [3:0]                               index
  );
    logic [6:0] bit_pos;
    bit_pos = 7'(16 * motion_cfg_pkg::WORD_COUNT - 8) - 7'({index, 3'b000});
    return words[bit_pos +: 8];
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  always_comb begin
    logic [3:0] rate_code;
    rate_code       = state.low_power_config[motion_cfg_pkg::WAKE_RATE_MSB:
                                             motion_cfg_pkg::WAKE_RATE_LSB];
    next_state      = state;
    next_state.push = 1'b0;

    // register writes
    if (reg_write) begin
      if (reg_hit(reg_addr, motion_cfg_pkg::ADDR_LOW_POWER_CONFIG)) begin
        next_state.low_power_config = reg_wdata;
      end
      if (reg_hit(reg_addr, motion_cfg_pkg::ADDR_WAKE_MOTION_THRESHOLD)) begin
        next_state.wake_motion_threshold = reg_wdata;
      end
      if (reg_hit(reg_addr, motion_cfg_pkg::ADDR_FIFO_SOURCE_SELECT)) begin
        next_state.source_sel = reg_wdata[7:motion_cfg_pkg::SRC_FIELD_LSB];
      end
    end

    // register reads, answered on the next edge
    if (reg_read) begin
      next_state.rdata = motion_cfg_pkg::RESET_RDATA;
      if (reg_hit(reg_addr, motion_cfg_pkg::ADDR_LOW_POWER_CONFIG)) begin
        next_state.rdata = state.low_power_config;
      end else if (reg_hit(reg_addr, motion_cfg_pkg::ADDR_WAKE_MOTION_THRESHOLD)) begin
        next_state.rdata = state.wake_motion_threshold;
      end else if (reg_hit(reg_addr, motion_cfg_pkg::ADDR_FIFO_SOURCE_SELECT)) begin
        next_state.rdata = {state.source_sel, 3'b000};
      end else if (reg_hit(reg_addr, motion_cfg_pkg::ADDR_FRAME_SYNC_IRQ_STATUS)) begin
        next_state.rdata[motion_cfg_pkg::FRAME_SYNC_FLAG_BIT] = state.irq_flag;
        next_state.irq_flag = 1'b0;
      end
    end
    // an event in the same cycle as the clearing read survives
    if (frame_sync_event) begin
      next_state.irq_flag = 1'b1;
    end

    // gyro filter choice: low-pass selection is masked while duty-cycling
    next_state.lowpass_applied = state.low_power_config[motion_cfg_pkg::GYRO_CYCLE_BIT]
                               ? 3'h0 : gyro_lowpass_sel;

    // wake rate takes effect only in the accel wake mode; reserved codes never take effect
    next_state.rate_active = gyro_off && accel_cycle_en
                           && (rate_code >= motion_cfg_pkg::WAKE_RATE_MIN)
                           && (rate_code <= motion_cfg_pkg::WAKE_RATE_MAX);
    next_state.rate_sel    = next_state.rate_active ? rate_code : 4'h0;

    // queue push sequencer, one byte slot per clock; standby paths still push
    case (state.seq)
      motion_cfg_pkg::SEQ_IDLE: begin
        if (sample_tick && (state.source_sel != 5'h00)) begin
          next_state.seq        = motion_cfg_pkg::SEQ_RUN;
          next_state.byte_index = 4'h0;
          next_state.snap_sel   = state.source_sel;
          next_state.snap_words = {temp_value, gyro_x_value, gyro_y_value, gyro_z_value,
                                   accel_x_value, accel_y_value, accel_z_value};
        end
      end
      motion_cfg_pkg::SEQ_RUN: begin
        if (source_enabled(state.snap_sel, state.byte_index[3:1])) begin
          next_state.push = 1'b1;
          next_state.data = snapshot_byte(state.snap_words, state.byte_index);
        end
        if (state.byte_index == motion_cfg_pkg::LAST_BYTE_INDEX) begin
          next_state.seq = motion_cfg_pkg::SEQ_IDLE;
        end else begin
          next_state.byte_index = state.byte_index + 4'h1;
        end
      end
      default: begin
        next_state.seq = motion_cfg_pkg::SEQ_IDLE;
      end
    endcase
  end

  // a sample tick during a running sequence is dropped; ticks are far slower than 15 clocks
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state                       <= '0;
      state.low_power_config      <= motion_cfg_pkg::RESET_LOW_POWER_CONFIG;
      state.wake_motion_threshold <= motion_cfg_pkg::RESET_WAKE_MOTION_THRESHOLD;
      state.source_sel            <= motion_cfg_pkg::RESET_FIFO_SOURCE_SELECT;
      state.seq                   <= motion_cfg_pkg::SEQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata            = state.rdata;
  assign gyro_cycle_en        = state.low_power_config[motion_cfg_pkg::GYRO_CYCLE_BIT];
  assign gyro_average_sel     = state.low_power_config[motion_cfg_pkg::AVG_SEL_MSB:
                                                       motion_cfg_pkg::AVG_SEL_LSB];
  assign gyro_lowpass_applied = state.lowpass_applied;
  assign wake_rate_active     = state.rate_active;
  assign wake_accel_rate_sel  = state.rate_sel;
  assign motion_threshold     = state.wake_motion_threshold;
  assign frame_sync_irq_flag  = state.irq_flag;
  assign queue_push           = state.push;
  assign queue_data           = state.data;
endmodule

/* hdl/motion_cfg_pkg.sv */
// constants and types shared by the low-power / queue-select register group
package motion_cfg_pkg;
  // register offsets
  localparam logic [7:0] ADDR_LOW_POWER_CONFIG      = 8'h1E;
  localparam logic [7:0] ADDR_WAKE_MOTION_THRESHOLD = 8'h1F;
  localparam logic [7:0] ADDR_FIFO_SOURCE_SELECT    = 8'h23;
  localparam logic [7:0] ADDR_FRAME_SYNC_IRQ_STATUS = 8'h36;

  // reset values
  localparam logic [7:0] RESET_LOW_POWER_CONFIG      = 8'h00;
  localparam logic [7:0] RESET_WAKE_MOTION_THRESHOLD = 8'h00;
  localparam logic [4:0] RESET_FIFO_SOURCE_SELECT    = 5'h00;
  localparam logic [7:0] RESET_RDATA                 = 8'h00;

  // low_power_config fields
  localparam int GYRO_CYCLE_BIT  = 7;
  localparam int AVG_SEL_MSB     = 6;
  localparam int AVG_SEL_LSB     = 4;
  localparam int WAKE_RATE_MSB   = 3;
  localparam int WAKE_RATE_LSB   = 0;
  localparam logic [3:0] WAKE_RATE_MIN = 4'h4;
  localparam logic [3:0] WAKE_RATE_MAX = 4'hB;

  // fifo_source_select fields: bits 7..3 are kept, bits 2..0 reserved
  localparam int SRC_FIELD_LSB   = 3;
  localparam int SRC_TEMP_BIT    = 7;
  localparam int SRC_GYRO_X_BIT  = 6;
  localparam int SRC_GYRO_Y_BIT  = 5;
  localparam int SRC_GYRO_Z_BIT  = 4;
  localparam int SRC_ACCEL_BIT   = 3;

  // frame-sync status field
  localparam int FRAME_SYNC_FLAG_BIT = 7;

  // queue push sequence: seven 16-bit words, fourteen bytes
  localparam int WORD_COUNT = 7;
  localparam logic [3:0] LAST_BYTE_INDEX = 4'hD;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } seq_state_t;
endpackage

/* hdl/sample_rate_divider.sv */
// divides the filter-rate tick by one plus the divider value
`timescale 1ns/10ps
module sample_rate_divider (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       filter_tick,
  input  wire logic [7:0] rate_divider,
  output logic            sample_tick
);
  typedef struct packed {
    logic [7:0] count;
    logic       tick;
  } div_state_t;

  div_state_t state;
  div_state_t next_state;

  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (filter_tick) begin
      if (state.count >= rate_divider) begin
        next_state.count = 8'h00;
        next_state.tick  = 1'b1;
      end else begin
        next_state.count = state.count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sample_tick = state.tick;
endmodule

/* hdl/frame_sync_detect.sv */
// synchronises the frame-sync pin and flags a transition to its active level
`timescale 1ns/10ps
module frame_sync_detect (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic frame_sync_pin,
  input  wire logic frame_sync_irq_en,
  input  wire logic frame_sync_irq_polarity,
  output logic      frame_sync_event
);
  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic last_level;
    logic event_pulse;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;
  logic        active_level;

  // polarity 1 means the pin is active low
  assign active_level = ~frame_sync_irq_polarity;

  always_comb begin
    next_state             = state;
    next_state.sync_first  = frame_sync_pin;
    next_state.sync_second = state.sync_first;
    next_state.last_level  = state.sync_second;
    next_state.event_pulse = frame_sync_irq_en
                           && (state.sync_second != state.last_level)
                           && (state.sync_second == active_level);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign frame_sync_event = state.event_pulse;
endmodule

/* tb/low_power_wake_fifo_select_cfg_checker.sv */
// concurrent checks on the ports of the low-power / queue-select register group
`timescale 1ns/10ps
module low_power_wake_fifo_select_cfg_checker (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_rdata,
  input  wire logic [2:0] gyro_lowpass_sel,
  input  wire logic       gyro_cycle_en,
  input  wire logic [2:0] gyro_average_sel,
  input  wire logic [2:0] gyro_lowpass_applied,
  input  wire logic       wake_rate_active,
  input  wire logic [3:0] wake_accel_rate_sel,
  input  wire logic [7:0] motion_threshold
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  cycle_bit_a: assert property (reg_write && reg_addr == 8'h1E |=>
    gyro_cycle_en == $past(reg_wdata[7])) else $error("cycle enable misses write");
  avg_field_a: assert property (reg_write && reg_addr == 8'h1E |=>
    gyro_average_sel == $past(reg_wdata[6:4])) else $error("averaging field misses write");
  lowpass_off_a: assert property (gyro_cycle_en && $past(gyro_cycle_en) |->
    gyro_lowpass_applied == 3'h0) else $error("low-pass used while cycling");
  lowpass_on_a: assert property (!gyro_cycle_en && !$past(gyro_cycle_en) && !$past(reset) |->
    gyro_lowpass_applied == $past(gyro_lowpass_sel)) else $error("low-pass not applied");
  wake_range_a: assert property (wake_rate_active |->
    wake_accel_rate_sel >= 4'h4 && wake_accel_rate_sel <= 4'hB) else $error("wake code out of range");
  wake_gate_a: assert property (!wake_rate_active |->
    wake_accel_rate_sel == 4'h0) else $error("wake rate shown while inactive");
  thresh_write_a: assert property (reg_write && reg_addr == 8'h1F |=>
    motion_threshold == $past(reg_wdata)) else $error("threshold misses write");
  src_reserved_a: assert property (reg_read && reg_addr == 8'h23 |=>
    reg_rdata[2:0] == 3'h0) else $error("reserved source bits read nonzero");
endmodule
bind low_power_wake_fifo_select_cfg low_power_wake_fifo_select_cfg_checker checker_i (
  .clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .gyro_lowpass_sel, .gyro_cycle_en, .gyro_average_sel, .gyro_lowpass_applied,
  .wake_rate_active, .wake_accel_rate_sel, .motion_threshold);

/* tb/reg_host.sv */
// host-side model driving the register port of the block
`timescale 1ns/10ps
module reg_host (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // callers only ask for wake codes 4..11; t_wake sets gyro off and accel cycling, t_low_power writes code 7 with both clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk_sys);
    reg_write = 1'b0;
    // released lines show the inverse so a stale value cannot pass for a fresh one
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk_sys);
    reg_read = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the low-power / queue-select register group
`timescale 1ns/10ps
module testbench;
  logic        clk_sys, reset, reg_write, reg_read, gyro_off, accel_cycle_en, filter_tick;
  logic        frame_sync_pin, frame_sync_irq_en, frame_sync_irq_polarity, gyro_cycle_en;
  logic        wake_rate_active, frame_sync_irq_flag, queue_push;
  logic [2:0]  gyro_lowpass_sel, gyro_average_sel, gyro_lowpass_applied;
  logic [3:0]  wake_accel_rate_sel;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rate_divider, motion_threshold, queue_data, v;
  logic [15:0] w [7];
  logic [7:0]  got [$];
  int          errors, n_tests, cycles;
  always #50 clk_sys = ~clk_sys;
  reg_host reg_host_i (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  low_power_wake_fifo_select_cfg low_power_wake_fifo_select_cfg_i (.clk_sys(clk_sys),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .gyro_off(gyro_off),
    .accel_cycle_en(accel_cycle_en), .gyro_lowpass_sel(gyro_lowpass_sel),
    .rate_divider(rate_divider), .filter_tick(filter_tick), .frame_sync_pin(frame_sync_pin),
    .frame_sync_irq_en(frame_sync_irq_en), .frame_sync_irq_polarity(frame_sync_irq_polarity),
    .temp_value(w[0]), .gyro_x_value(w[1]), .gyro_y_value(w[2]), .gyro_z_value(w[3]),
    .accel_x_value(w[4]), .accel_y_value(w[5]), .accel_z_value(w[6]),
    .gyro_cycle_en(gyro_cycle_en), .gyro_average_sel(gyro_average_sel),
    .gyro_lowpass_applied(gyro_lowpass_applied), .wake_rate_active(wake_rate_active),
    .wake_accel_rate_sel(wake_accel_rate_sel), .motion_threshold(motion_threshold),
    .frame_sync_irq_flag(frame_sync_irq_flag), .queue_push(queue_push), .queue_data(queue_data));
  // sampled half a cycle after launch so the capture never races the pushing edge
  always @(negedge clk_sys) if (queue_push === 1'b1) got.push_back(queue_data);
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_reset();
    foreach (w[i]) reg_host_i.rd(i[0] ? 8'h1E : (i[1] ? 8'h23 : 8'h36), v);
    check("reset readback", {8'h00, v}, 16'h0000);
    reg_host_i.rd(8'h1F, v);
    check("reset outputs", {v, 5'h0, gyro_average_sel}, 16'h0000);
  endtask
  task automatic t_low_power();
    gyro_lowpass_sel = 3'h5;
    reg_host_i.wr(8'h1E, 8'h37);
    repeat (3) @(negedge clk_sys);
    check("lowpass normal", {13'h0, gyro_lowpass_applied}, 16'h0005);
    check("average sel", {13'h0, gyro_average_sel}, 16'h0003);
    reg_host_i.wr(8'h1E, 8'hB7);
    repeat (3) @(negedge clk_sys);
    check("cycle enable", {15'h0, gyro_cycle_en}, 16'h0001);
    check("lowpass cycling", {13'h0, gyro_lowpass_applied}, 16'h0000);
    reg_host_i.rd(8'h1E, v);
    check("low power readback", {8'h00, v}, 16'h00B7);
  endtask
  task automatic t_wake();
    gyro_off = 1'b1;
    accel_cycle_en = 1'b1;
    for (int c = 4; c <= 11; c++) begin
      reg_host_i.wr(8'h1E, 8'(c));
      repeat (2) @(negedge clk_sys);
      check("wake rate", {11'h0, wake_rate_active, wake_accel_rate_sel}, 16'(16 + c));
    end
    gyro_off = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("wake gyro on", {11'h0, wake_rate_active, wake_accel_rate_sel}, 16'h0000);
    gyro_off = 1'b1;
    accel_cycle_en = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("wake no cycle", {11'h0, wake_rate_active, wake_accel_rate_sel}, 16'h0000);
  endtask
  task automatic t_threshold();
    reg_host_i.wr(8'h1F, 8'hA5);
    reg_host_i.rd(8'h1F, v);
    check("threshold", {motion_threshold, v}, 16'hA5A5);
    reg_host_i.wr(8'h36, 8'hFF);
    reg_host_i.rd(8'h50, v);
    check("unmapped read", {8'h00, v}, 16'h0000);
    reg_host_i.rd(8'h36, v);
    check("status not writable", {8'h00, v}, 16'h0000);
  endtask
  // sources sit in standby (gyro off) on purpose: queued data must not depend on that
  task automatic queue_case(input logic [7:0] sel, input logic [15:0] base, input int ticks);
    logic [7:0] e [$];
    got.delete();
    for (int i = 0; i < 7; i++) w[i] = base + 16'(i) * 16'h1111;
    reg_host_i.wr(8'h23, sel);
    reg_host_i.rd(8'h23, v);
    check("source readback", {8'h00, v}, {8'h00, sel[7:3], 3'h0});
    for (int t = 0; t < ticks; t++) begin
      @(negedge clk_sys);
      filter_tick = 1'b1;
      @(negedge clk_sys);
      filter_tick = 1'b0;
      repeat (20) @(negedge clk_sys);
    end
    for (int r = 0; r < ticks / (rate_divider + 1); r++)
      for (int i = 0; i < 7; i++)
        if (sel[i == 0 ? 7 : (i < 4 ? 7 - i : 3)]) begin
          e.push_back(w[i][15:8]);
          e.push_back(w[i][7:0]);
        end
    check("queue count", 16'(got.size()), 16'(e.size()));
    foreach (e[k]) if (k < got.size()) check("queue byte", {8'h00, got[k]}, {8'h00, e[k]});
  endtask
  task automatic t_frame_sync_pin(input logic en, input logic pol, input logic exp);
    reg_host_i.rd(8'h36, v);
    frame_sync_irq_en = en;
    frame_sync_irq_polarity = pol;
    frame_sync_pin = pol;
    repeat (5) @(negedge clk_sys);
    frame_sync_pin = ~pol;
    repeat (6) @(negedge clk_sys);
    check("sync flag", {15'h0, frame_sync_irq_flag}, {15'h0, exp});
    reg_host_i.rd(8'h36, v);
    check("sync status", {7'h00, frame_sync_irq_flag, v}, {8'h00, exp, 7'h00});
    reg_host_i.rd(8'h36, v);
    check("sync cleared", {8'h00, v}, 16'h0000);
    frame_sync_pin = pol;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    {clk_sys, reset, gyro_off, accel_cycle_en, filter_tick, frame_sync_pin} = 6'b010000;
    {frame_sync_irq_en, frame_sync_irq_polarity, gyro_lowpass_sel, rate_divider} = 13'h0;
    foreach (w[i]) w[i] = 16'h0000;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    t_reset();
    t_low_power();
    t_wake();
    t_threshold();
    queue_case(8'hAF, 16'h1020, 1);
    queue_case(8'h50, 16'h3132, 1);
    rate_divider = 8'h02;
    queue_case(8'h80, 16'h4050, 6);
    t_frame_sync_pin(1'b1, 1'b0, 1'b1);
    t_frame_sync_pin(1'b1, 1'b1, 1'b1);
    t_frame_sync_pin(1'b0, 1'b0, 1'b0);
    end_sim();
  end
endmodule
